/* hdl/burst_sram_command_scheduler.sv */
// Summary of operation
// - scheduler idles until a read or write command is pending
// - never issue two transactions of the same type back to back
// - after write go read if pending; after read go write if pending
// - write-ready high while write command fifo has room
// - one-cycle read command; data returns later with read-valid high
// - read-ready high while read command fifo has room
// - return data advances on read-acknowledge, or whenever read-valid is low
// - write burst starts when scheduler enters write state
// - write beats carry words one-two then three-four, 18 bits each
// - after second write beat, loop to first beat if write pending
// - read capture starts only on sram output valid
// - read beats capture words one-two then three-four into 72 bits
// - after second read beat, loop to first beat if data continues
// - application sees a single-rate 72-bit dual-port memory
// - fifos carry commands and write data to the sram clock, read data back to the core clock
`timescale 1ns/1ps
module cross_fifo #(
  parameter int W = 8,
  parameter int AW = 3
) (
  input wire logic wclk,
  input wire logic wrst_n,
  input wire logic w_valid,
  input wire logic [W-1:0] w_data,
  output logic w_ready,
  output logic [AW:0] w_used,
  input wire logic rclk,
  input wire logic rrst_n,
  output logic r_valid,
  output logic [W-1:0] r_data,
  input wire logic r_pop
);
  localparam int PW = AW + 1;
  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray
  function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : from_gray

  logic [W-1:0] mem [1 << AW];
  logic [PW-1:0] wbin_ff, wgray_ff, rg1_ff, rg2_ff;
  logic [PW-1:0] rbin_ff, rgray_ff, wg1_ff, wg2_ff;
  // write side pointers and full flag from next pointer
  wire w_push = w_valid & w_ready;
  wire [PW-1:0] nxt_wbin = wbin_ff + {{AW{1'b0}}, w_push};
  wire [PW-1:0] nxt_wgray = to_gray(nxt_wbin);
  wire [PW-1:0] full_gray = {~rg2_ff[PW-1:PW-2], rg2_ff[PW-3:0]};
  assign w_used = wbin_ff - from_gray(rg2_ff);
  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      {wbin_ff, wgray_ff, rg1_ff, rg2_ff} <= '0;
      w_ready <= 1'b1;
    end else begin
      {wbin_ff, wgray_ff} <= {nxt_wbin, nxt_wgray};
      {rg1_ff, rg2_ff} <= {rgray_ff, rg1_ff};
      w_ready <= nxt_wgray != full_gray;
    end
  end
  always_ff @(posedge wclk) begin
    if (w_push) mem[wbin_ff[AW-1:0]] <= w_data;
  end
  // read side, show-ahead data
  wire r_take = r_pop & r_valid;
  wire [PW-1:0] nxt_rbin = rbin_ff + {{AW{1'b0}}, r_take};
  wire [PW-1:0] nxt_rgray = to_gray(nxt_rbin);
  assign r_data = mem[rbin_ff[AW-1:0]];
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      {rbin_ff, rgray_ff, wg1_ff, wg2_ff} <= '0;
      r_valid <= 1'b0;
    end else begin
      {rbin_ff, rgray_ff} <= {nxt_rbin, nxt_rgray};
      {wg1_ff, wg2_ff} <= {wgray_ff, wg1_ff};
      r_valid <= nxt_rgray != wg2_ff;
    end
  end
endmodule : cross_fifo

module burst_sram_command_scheduler #(
  parameter int CMD_AW = sram_sched_pkg::CMD_AW,
  parameter int RET_AW = sram_sched_pkg::RET_AW
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sram_sched_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wr_cmd,
  input wire logic [sram_sched_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [sram_sched_pkg::DATA_W-1:0] wr_data,
  input wire logic [sram_sched_pkg::BE_W-1:0] wr_be,
  output logic wr_ready,
  input wire logic rd_cmd,
  input wire logic [sram_sched_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_ready,
  output logic rd_valid,
  output logic [sram_sched_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_ack,
  input wire logic sram_clk,
  input wire sram_sched_pkg::sram_in_t sram_i,
  output sram_sched_pkg::sram_out_t sram_o
);
  localparam int WW = sram_sched_pkg::WORD_W;
  localparam int RPW = RET_AW + 1;
  localparam logic [RPW:0] RET_DEPTH = (RPW + 1)'(1 << RET_AW);

  // reset synchronisers, one per domain
  logic rs1_ff, rst_ok_ff, ls1_ff, lrst_ok_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) {rs1_ff, rst_ok_ff} <= 2'b00;
    else {rs1_ff, rst_ok_ff} <= {1'b1, rs1_ff};
  end
  always_ff @(posedge sram_clk or negedge rst_n) begin
    if (!rst_n) {ls1_ff, lrst_ok_ff} <= 2'b00;
    else {ls1_ff, lrst_ok_ff} <= {1'b1, ls1_ff};
  end

  // application write and read command fifos into the sram domain
  sram_sched_pkg::wr_req_t wr_head;
  logic [sram_sched_pkg::ADDR_W-1:0] rd_head;
  logic wq_valid, rq_valid, wq_pop, rq_pop;
  logic ret_push, ret_ready, ret_valid, ret_pop;
  logic [RPW-1:0] ret_used;
  logic [sram_sched_pkg::DATA_W-1:0] ret_wdata, ret_rdata;
  cross_fifo #(.W($bits(sram_sched_pkg::wr_req_t)), .AW(CMD_AW)) u_wq (
    .wclk(core_clk), .wrst_n(rst_ok_ff), .w_valid(wr_cmd),
    .w_data({wr_addr, wr_be, wr_data}), .w_ready(wr_ready),
    .w_used(), .rclk(sram_clk), .rrst_n(lrst_ok_ff),
    .r_valid(wq_valid), .r_data(wr_head), .r_pop(wq_pop)
  );
  cross_fifo #(.W(sram_sched_pkg::ADDR_W), .AW(CMD_AW)) u_rq (
    .wclk(core_clk), .wrst_n(rst_ok_ff), .w_valid(rd_cmd),
    .w_data(rd_addr), .w_ready(rd_ready), .w_used(),
    .rclk(sram_clk), .rrst_n(lrst_ok_ff),
    .r_valid(rq_valid), .r_data(rd_head), .r_pop(rq_pop)
  );
  cross_fifo #(.W(sram_sched_pkg::DATA_W), .AW(RET_AW)) u_ret (
    .wclk(sram_clk), .wrst_n(lrst_ok_ff), .w_valid(ret_push),
    .w_data(ret_wdata), .w_ready(ret_ready), .w_used(ret_used),
    .rclk(core_clk), .rrst_n(rst_ok_ff),
    .r_valid(ret_valid), .r_data(ret_rdata), .r_pop(ret_pop)
  );

  // return staging register toward the application
  logic rd_valid_ff;
  logic [sram_sched_pkg::DATA_W-1:0] rd_data_ff;
  logic [31:0] count_ff;
  assign ret_pop = ~rd_valid_ff | rd_ack;
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;
  always_ff @(posedge core_clk or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
    end else if (ret_pop) begin
      rd_valid_ff <= ret_valid;
      rd_data_ff <= ret_valid ? ret_rdata : rd_data_ff;
    end
  end

  // apb slave, zero wait states after setup
  logic ctrl_en_ff, pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready_ff & pwrite;
  wire hit_ctrl = paddr == sram_sched_pkg::CTRL_OFS;
  wire hit_stat = paddr == sram_sched_pkg::STATUS_OFS;
  wire hit_cnt = paddr == sram_sched_pkg::COUNT_OFS;
  wire [31:0] stat_word =
    (32'(wr_ready) << sram_sched_pkg::STAT_WR_RDY_BIT) |
    (32'(rd_ready) << sram_sched_pkg::STAT_RD_RDY_BIT) |
    (32'(rd_valid_ff) << sram_sched_pkg::STAT_RD_VLD_BIT);
  wire [31:0] rd_mux =
    hit_ctrl ? 32'(ctrl_en_ff) << sram_sched_pkg::CTRL_EN_BIT :
    hit_stat ? stat_word : hit_cnt ? count_ff : 32'h00000000;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  always_ff @(posedge core_clk or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      {pready_ff, pslverr_ff, prdata_ff} <= '0;
      ctrl_en_ff <= sram_sched_pkg::CTRL_EN_RESET;
      count_ff <= 32'h00000000;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup & ~(hit_ctrl | hit_stat | hit_cnt);
      prdata_ff <= (apb_setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (apb_wr && hit_ctrl)
        ctrl_en_ff <= pwdata[sram_sched_pkg::CTRL_EN_BIT];
      if (rd_valid_ff && rd_ack) count_ff <= count_ff + 32'h00000001;
    end
  end

  // sram domain: enable sync, pin capture, read credit
  logic en1_ff, en2_ff;
  sram_sched_pkg::sram_in_t sin1_ff, sin2_ff;
  logic [RPW-1:0] inflight_ff;
  sram_sched_pkg::sched_t sched_ff, nxt_sched;
  sram_sched_pkg::beat_t wsm_ff, nxt_wsm, rsm_ff, nxt_rsm;
  sram_sched_pkg::wr_req_t hold_ff;
  sram_sched_pkg::sram_out_t sram_o_ff, nxt_sram_o;
  logic [2*WW-1:0] cap_ff;
  wire credit_ok = ({1'b0, inflight_ff} + {1'b0, ret_used}) < RET_DEPTH;
  wire wr_pend = wq_valid & en2_ff;
  wire rd_pend = rq_valid & en2_ff & credit_ok;
  assign sram_o = sram_o_ff;

  // main scheduler: interleave, never repeat a type
  always_comb begin
    unique case (sched_ff)
      sram_sched_pkg::S_IDLE: nxt_sched = wr_pend ? sram_sched_pkg::S_WRITE :
        rd_pend ? sram_sched_pkg::S_READ : sram_sched_pkg::S_IDLE;
      sram_sched_pkg::S_WRITE: nxt_sched = rd_pend ?
        sram_sched_pkg::S_READ : sram_sched_pkg::S_IDLE;
      sram_sched_pkg::S_READ: nxt_sched = wr_pend ?
        sram_sched_pkg::S_WRITE : sram_sched_pkg::S_IDLE;
      default: nxt_sched = sram_sched_pkg::S_IDLE;
    endcase
  end
  assign wq_pop = nxt_sched == sram_sched_pkg::S_WRITE;
  assign rq_pop = nxt_sched == sram_sched_pkg::S_READ;

  // write beats follow the scheduler's write state
  assign nxt_wsm = wq_pop ? sram_sched_pkg::B_FIRST :
    (wsm_ff == sram_sched_pkg::B_FIRST) ? sram_sched_pkg::B_SECOND :
    sram_sched_pkg::B_IDLE;
  // read beats start on sram output valid
  assign nxt_rsm = (rsm_ff == sram_sched_pkg::B_FIRST) ?
    sram_sched_pkg::B_SECOND : sin2_ff.output_valid ?
    sram_sched_pkg::B_FIRST : sram_sched_pkg::B_IDLE;
  assign ret_push = rsm_ff == sram_sched_pkg::B_FIRST;
  assign ret_wdata = {sin2_ff.q_fall, sin2_ff.q_rise, cap_ff};

  // next pin values; words one-two then three-four
  always_comb begin
    nxt_sram_o = sram_o_ff;
    nxt_sram_o.wps_n = ~wq_pop;
    nxt_sram_o.rps_n = ~rq_pop;
    nxt_sram_o.bw_rise_n = '1;
    nxt_sram_o.bw_fall_n = '1;
    if (wq_pop) begin
      nxt_sram_o.addr = wr_head.addr;
      nxt_sram_o.d_rise = wr_head.data[0 +: WW];
      nxt_sram_o.d_fall = wr_head.data[WW +: WW];
      nxt_sram_o.bw_rise_n = ~wr_head.be[1:0];
      nxt_sram_o.bw_fall_n = ~wr_head.be[3:2];
    end else if (nxt_wsm == sram_sched_pkg::B_SECOND) begin
      nxt_sram_o.d_rise = hold_ff.data[2*WW +: WW];
      nxt_sram_o.d_fall = hold_ff.data[3*WW +: WW];
      nxt_sram_o.bw_rise_n = ~hold_ff.be[5:4];
      nxt_sram_o.bw_fall_n = ~hold_ff.be[7:6];
    end
    if (rq_pop) nxt_sram_o.addr = rd_head;
  end

  // sram domain state
  always_ff @(posedge sram_clk or negedge lrst_ok_ff) begin
    if (!lrst_ok_ff) begin
      {en1_ff, en2_ff, sin1_ff, sin2_ff, cap_ff, hold_ff} <= '0;
      sched_ff <= sram_sched_pkg::S_IDLE;
      wsm_ff <= sram_sched_pkg::B_IDLE;
      rsm_ff <= sram_sched_pkg::B_IDLE;
      inflight_ff <= '0;
      sram_o_ff <= '{addr: '0, wps_n: 1'b1, rps_n: 1'b1, d_rise: '0,
        d_fall: '0, bw_rise_n: '1, bw_fall_n: '1};
    end else begin
      {en1_ff, en2_ff} <= {ctrl_en_ff, en1_ff};
      {sin1_ff, sin2_ff} <= {sram_i, sin1_ff};
      {sched_ff, wsm_ff, rsm_ff} <= {nxt_sched, nxt_wsm, nxt_rsm};
      sram_o_ff <= nxt_sram_o;
      if (wq_pop) hold_ff <= wr_head;
      if (nxt_rsm == sram_sched_pkg::B_FIRST)
        cap_ff <= {sin2_ff.q_fall, sin2_ff.q_rise};
      inflight_ff <= inflight_ff + RPW'(rq_pop) - RPW'(ret_push);
    end
  end

  // checks in the sram domain, plus return hold and cover on the core clock
  property p_idle_wait;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    sched_ff == sram_sched_pkg::S_IDLE && !wr_pend && !rd_pend
    |=> sched_ff == sram_sched_pkg::S_IDLE;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("idle left");
  property p_no_repeat;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    sched_ff != sram_sched_pkg::S_IDLE |=> sched_ff != $past(sched_ff);
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("same type");
  property p_wr_to_rd;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    sched_ff == sram_sched_pkg::S_WRITE && rd_pend
    |=> sched_ff == sram_sched_pkg::S_READ ##0 !sram_o_ff.rps_n;
  endproperty
  a_wr_to_rd: assert property (p_wr_to_rd) else $error("no read");
  property p_wr_start;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    sched_ff == sram_sched_pkg::S_WRITE |-> wsm_ff == sram_sched_pkg::B_FIRST
      && !sram_o_ff.wps_n ##1 wsm_ff == sram_sched_pkg::B_SECOND;
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("no burst");
  property p_wr_second;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    wsm_ff == sram_sched_pkg::B_SECOND |->
      sram_o_ff.d_fall == hold_ff.data[3*WW +: WW];
  endproperty
  a_wr_second: assert property (p_wr_second) else $error("beat 2");
  property p_wr_loop;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    wsm_ff == sram_sched_pkg::B_SECOND && wq_pop
    |=> wsm_ff == sram_sched_pkg::B_FIRST;
  endproperty
  a_wr_loop: assert property (p_wr_loop) else $error("no loop");
  property p_rd_wait;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    rsm_ff != sram_sched_pkg::B_FIRST && !sin2_ff.output_valid
    |=> rsm_ff != sram_sched_pkg::B_FIRST && !ret_push;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("early cap");
  property p_rd_asm;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    ret_push |-> ret_wdata[2*WW-1:0] ==
      $past({sin2_ff.q_fall, sin2_ff.q_rise}) && $past(sin2_ff.output_valid);
  endproperty
  a_rd_asm: assert property (p_rd_asm) else $error("bad word");
  property p_rd_loop;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    rsm_ff == sram_sched_pkg::B_SECOND && sin2_ff.output_valid
    |=> ret_push;
  endproperty
  a_rd_loop: assert property (p_rd_loop) else $error("rd loop");
  // credit keeps the return fifo from ever refusing a word
  property p_ret_room;
    @(posedge sram_clk) disable iff (!lrst_ok_ff)
    ret_push |-> ret_ready;
  endproperty
  a_ret_room: assert property (p_ret_room) else $error("ret full");
  property p_ack_hold;
    @(posedge core_clk) disable iff (!rst_ok_ff)
    rd_valid && !rd_ack |=> rd_valid && $stable(rd_data);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data moved");
  c_interleave: cover property (@(posedge sram_clk)
    sched_ff == sram_sched_pkg::S_WRITE ##1 sched_ff == sram_sched_pkg::S_READ
    ##1 sched_ff == sram_sched_pkg::S_WRITE);
  c_rd_chain: cover property (@(posedge sram_clk) ret_push ##2 ret_push);
  c_return: cover property (@(posedge core_clk) rd_valid && rd_ack);
endmodule : burst_sram_command_scheduler

/* inc/sram_sched_pkg.sv */
package sram_sched_pkg;
  localparam int ADDR_W = 20;
  localparam int WORD_W = 18;
  localparam int DATA_W = 72;
  localparam int BE_W = 8;
  localparam int BEAT_BE_W = 2;
  localparam int CMD_AW = 3;
  localparam int RET_AW = 3;
  localparam int APB_AW = 12;
  // register offsets (byte addresses)
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] COUNT_OFS = 12'h008;
  // field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_WR_RDY_BIT = 0;
  localparam int STAT_RD_RDY_BIT = 1;
  localparam int STAT_RD_VLD_BIT = 2;
  localparam logic CTRL_EN_RESET = 1'b1;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_WRITE = 2'b01, S_READ = 2'b11
  } sched_t;
  typedef enum logic [1:0] {
    B_IDLE = 2'b00, B_FIRST = 2'b01, B_SECOND = 2'b11
  } beat_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be;
    logic [DATA_W-1:0] data;
  } wr_req_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wps_n;
    logic rps_n;
    logic [WORD_W-1:0] d_rise;
    logic [WORD_W-1:0] d_fall;
    logic [BEAT_BE_W-1:0] bw_rise_n;
    logic [BEAT_BE_W-1:0] bw_fall_n;
  } sram_out_t;
  typedef struct packed {
    logic output_valid;
    logic [WORD_W-1:0] q_rise;
    logic [WORD_W-1:0] q_fall;
  } sram_in_t;
endpackage : sram_sched_pkg

/* dv/qdr_burst_model.sv */
`timescale 1ns/1ps
module qdr_burst_model #(
  parameter int LAT = 2
) (
  input wire logic sram_clk,
  input wire sram_sched_pkg::sram_out_t sram_o,
  output sram_sched_pkg::sram_in_t sram_i
);
  logic [71:0] mem [int];
  logic [71:0] rq [$];
  int rt [$];
  int cyc = 0;
  int wa = -1;
  logic [35:0] wlo;
  logic [3:0] blo;
  logic [71:0] rw;
  logic [71:0] nw;
  logic [7:0] be;
  logic rd2 = 1'b0;
  initial sram_i = '0;
  // write lands before a read in the same cycle sees the array
  always @(posedge sram_clk) begin
    cyc++;
    if (wa >= 0) begin
      nw = {sram_o.d_fall, sram_o.d_rise, wlo};
      be = ~{sram_o.bw_fall_n, sram_o.bw_rise_n, blo};
      if (!mem.exists(wa)) mem[wa] = '0;
      for (int i = 0; i < 8; i++) if (be[i]) mem[wa][9*i+:9] = nw[9*i+:9];
      wa = -1;
    end
    if (sram_o.wps_n === 1'b0) begin
      wa = int'(sram_o.addr);
      wlo = {sram_o.d_fall, sram_o.d_rise};
      blo = {sram_o.bw_fall_n, sram_o.bw_rise_n};
    end
    if (sram_o.rps_n === 1'b0) begin
      rq.push_back(mem.exists(int'(sram_o.addr)) ?
        mem[int'(sram_o.addr)] : '0);
      rt.push_back(cyc + LAT);
    end
    // valid with words one-two, then three-four, else toggling junk
    if (rd2) begin
      sram_i <= {1'b0, rw[53:36], rw[71:54]};
      rd2 = 1'b0;
    end else if (rt.size() > 0 && rt[0] <= cyc) begin
      rw = rq.pop_front();
      void'(rt.pop_front());
      sram_i <= {1'b1, rw[17:0], rw[35:18]};
      rd2 = 1'b1;
    end else begin
      sram_i <= {1'b0, ~sram_i.q_rise, ~sram_i.q_fall};
    end
  end
endmodule : qdr_burst_model

/* dv/test_burst_sram_command_scheduler.sv */
`timescale 1ns/1ps
module test_burst_sram_command_scheduler;
  logic core_clk = 1'b0;
  logic sram_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic wr_cmd = 1'b0, rd_cmd = 1'b0, rd_ack = 1'b0;
  logic [19:0] wr_addr = '0, rd_addr = '0;
  logic [71:0] wr_data = '0;
  logic [71:0] rd_data, d0;
  logic [7:0] wr_be = '0;
  logic wr_ready, rd_ready, rd_valid, full_w, full_r;
  logic pw = 1'b1, pr = 1'b1;
  logic ww, rr;
  sram_sched_pkg::sram_in_t sram_i;
  sram_sched_pkg::sram_out_t sram_o;
  logic [71:0] shadow [int];
  logic [71:0] expq [$];
  int miscompares = 0;
  int cmp_count = 0;
  int acked = 0, wr_rd = 0, accw = 0, accr = 0, base, bw, br;

  initial forever #25 core_clk = ~core_clk;
  initial begin
    #13;
    forever #80 sram_clk = ~sram_clk;
  end

  burst_sram_command_scheduler dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wr_cmd(wr_cmd), .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be),
    .wr_ready(wr_ready), .rd_cmd(rd_cmd), .rd_addr(rd_addr),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_ack(rd_ack), .sram_clk(sram_clk), .sram_i(sram_i), .sram_o(sram_o));
  qdr_burst_model mem_u (.sram_clk(sram_clk), .sram_o(sram_o),
    .sram_i(sram_i));

  task automatic chk(input string nm, input logic [71:0] ex,
    input logic [71:0] got);
    cmp_count++;
    if (got !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one cycle of commands; shadow follows what the edge accepted
  task automatic post(input logic dw, input logic dr, input int a,
    input logic [71:0] d, input logic [7:0] b);
    wr_cmd <= dw;
    rd_cmd <= dr;
    wr_addr <= 20'(a);
    rd_addr <= 20'(a);
    wr_data <= d;
    wr_be <= b;
    @(posedge core_clk);
    if (wr_cmd === 1'b1 && wr_ready === 1'b1) begin
      accw++;
      if (!shadow.exists(a)) shadow[a] = '0;
      for (int i = 0; i < 8; i++) if (b[i]) shadow[a][9*i+:9] = d[9*i+:9];
    end
    if (rd_cmd === 1'b1 && rd_ready === 1'b1) begin
      accr++;
      expq.push_back(shadow.exists(a) ? shadow[a] : '0);
    end
  endtask : post

  task automatic wait_drain();
    for (int n = 0; n < 3000 && expq.size() > 0; n++) @(posedge core_clk);
    chk("pending_reads", 72'h0, 72'(expq.size()));
  endtask : wait_drain

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // returned words in command order
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1 && rd_ack === 1'b1) begin
      acked++;
      chk("rd_data", expq.size() > 0 ? expq.pop_front() : 'x,
        rd_data);
    end
  end

  // no two address cycles of one kind back to back
  always @(posedge sram_clk) begin
    if (rst_n === 1'b1) begin
      ww = sram_o.wps_n === 1'b0 && pw === 1'b0;
      rr = sram_o.rps_n === 1'b0 && pr === 1'b0;
      chk("wr_gap", 72'h0, 72'(ww));
      chk("rd_gap", 72'h0, 72'(rr));
      if (pw === 1'b0 && sram_o.rps_n === 1'b0) wr_rd++;
    end
    pw = sram_o.wps_n;
    pr = sram_o.rps_n;
  end

  initial begin
    #3000000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    apb(1'b0, sram_sched_pkg::CTRL_OFS, '0);
    chk("ctrl", 72'(sram_sched_pkg::CTRL_EN_RESET), 72'(q));
    apb(1'b1, sram_sched_pkg::STATUS_OFS, 32'h0);
    apb(1'b0, sram_sched_pkg::STATUS_OFS, '0);
    chk("status", 72'h3, 72'(q));
    apb(1'b0, 12'h00C, '0);
    chk("pslverr", 72'h1, 72'(e));
    // full word, byte-masked overwrite, partial word, then reads
    rd_ack <= 1'b1;
    post(1'b1, 1'b0, 5, 72'h123456789ABCDEF012, 8'hFF);
    post(1'b1, 1'b0, 5, 72'hFEDCBA98765432100F, 8'hA5);
    post(1'b1, 1'b0, 6, 72'h3C3C3C3C3C3C3C3C3C, 8'h0F);
    // ports are independent: let the writes land before reading back
    post(1'b0, 1'b0, 0, '0, '0);
    repeat (60) @(posedge core_clk);
    post(1'b0, 1'b1, 5, '0, '0);
    post(1'b0, 1'b1, 6, '0, '0);
    post(1'b0, 1'b0, 0, '0, '0);
    wait_drain();
    // data holds until acknowledged
    rd_ack <= 1'b0;
    post(1'b0, 1'b1, 6, '0, '0);
    post(1'b0, 1'b0, 0, '0, '0);
    for (int n = 0; n < 500 && rd_valid !== 1'b1; n++) @(posedge core_clk);
    d0 = rd_data;
    apb(1'b0, sram_sched_pkg::STATUS_OFS, '0);
    chk("status_vld", 72'h1, 72'(q[sram_sched_pkg::STAT_RD_VLD_BIT]));
    repeat (8) @(posedge core_clk);
    chk("hold_vld", 72'h1, 72'(rd_valid));
    chk("hold_data", d0, rd_data);
    rd_ack <= 1'b1;
    wait_drain();
    // fill both fifos while issuing is stopped, then interleave
    apb(1'b1, sram_sched_pkg::CTRL_OFS, 32'h0);
    full_w = 1'b0;
    full_r = 1'b0;
    bw = accw;
    br = accr;
    base = wr_rd;
    for (int i = 0; i < 20; i++) begin
      post(1'b1, 1'b1, 16 + i, {4{18'(i * 7 + 1)}}, 8'hFF);
      full_w |= (wr_ready === 1'b0);
      full_r |= (rd_ready === 1'b0);
    end
    post(1'b0, 1'b0, 0, '0, '0);
    chk("wr_full", 72'h1, 72'(full_w));
    chk("rd_full", 72'h1, 72'(full_r));
    apb(1'b1, sram_sched_pkg::CTRL_OFS, 32'h1);
    wait_drain();
    bw = accw - bw;
    br = accr - br;
    chk("wr_then_rd", 72'(bw < br ? bw : br), 72'(wr_rd - base));
    apb(1'b0, sram_sched_pkg::COUNT_OFS, '0);
    chk("count", 72'(acked), 72'(q));
    final_report();
  end
endmodule : test_burst_sram_command_scheduler
